// ==== agw_aux_gpio.sv ====
`timescale 1ns/1ps
`default_nettype none
module agw_aux_gpio (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic main_rst_n_i,
  input wire logic bus_rst_i,
  input wire logic standby_rst_n_i,
  input wire agw_pkg::agw_bus_type bus_i,
  output logic [7:0] rdata_o,
  input wire logic [4:0] pin_i,
  output logic [4:0] pin_o,
  output logic [4:0] pin_oe_o,
  input wire agw_pkg::agw_alt_type alt_i,
  input wire logic [3:0] parallel_data_i,
  input wire logic kbc_port_bit_a_i,
  input wire logic kbc_port_bit_b_i,
  input wire logic ring_filter_sel_i,
  input wire logic game_port_access_i,
  input wire logic kbd_irq_i,
  input wire logic mouse_irq_i,
  input wire logic group_one_src_i,
  output logic [15:0] host_irq_o,
  output logic [4:0] pin_value_o,
  output logic power_led_output_o,
  output logic watchdog_timeout_output_o
);
  import agw_pkg::*;

  logic [7:0] pin_cfg_q [4];
  logic [7:0] irq_two_q, irq_one_q, wd_units_q, wd_count_q, wd_cfg_q, wd_ctrl_q;
  logic [4:0] pin_s1_q, pin_s2_q;
  logic [4:0] ev_s1_q, ev_s2_q, ev_prev_q;
  logic soft_rst;
  logic [29:0] sec_cnt_q;
  logic [5:0] min_cnt_q;
  logic [7:0] wd_left_q;
  logic led_q;
  logic [1:0] filt_q;
  logic [7:0] deb_cnt_q [2];
  logic [1:0] grp_raw;
  logic reload, tick_sec, unit_tick, expire;
  logic [4:0] pin_val;

  assign soft_rst = !main_rst_n_i || bus_rst_i;

  // pin configuration registers sit in the battery domain only
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        pin_cfg_q[i] <= PIN_CFG_RST;
      end
    end else if (bus_i.wr) begin
      for (int i = 0; i < 4; i++) begin
        if (bus_i.addr == PIN4_CFG_OFS + 8'(i)) begin
          pin_cfg_q[i] <= bus_i.wdata & PIN_CFG_WMASK;
        end
      end
    end
  end

  // combined interrupt registers, low bits forced zero
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_two_q <= ZERO_RST;
      irq_one_q <= ZERO_RST;
    end else if (bus_i.wr) begin
      if (bus_i.addr == IRQ_TWO_OFS) irq_two_q <= bus_i.wdata & IRQ_CFG_WMASK;
      if (bus_i.addr == IRQ_ONE_OFS) irq_one_q <= bus_i.wdata & IRQ_CFG_WMASK;
    end
  end

  // units and count clear on main or bus reset, a clocked clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_units_q <= ZERO_RST;
      wd_count_q <= ZERO_RST;
    end else if (soft_rst) begin
      wd_units_q <= ZERO_RST;
      wd_count_q <= ZERO_RST;
    end else if (bus_i.wr) begin
      if (bus_i.addr == WD_UNITS_OFS) wd_units_q <= bus_i.wdata & WD_UNITS_WMASK;
      if (bus_i.addr == WD_COUNT_OFS) wd_count_q <= bus_i.wdata;
    end
  end

  // watchdog config: standby reset clears all, main/bus keeps bit1
  always_ff @(posedge ref_clk_i or negedge standby_rst_n_i) begin
    if (!standby_rst_n_i) begin
      wd_cfg_q <= ZERO_RST;
    end else if (soft_rst) begin
      wd_cfg_q <= wd_cfg_q & WD_CFG_HOSTCLR;
    end else if (bus_i.wr && bus_i.addr == WD_CFG_OFS) begin
      wd_cfg_q <= bus_i.wdata;
    end
  end

  // status: expiry wins over a software clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge standby_rst_n_i) begin
    if (!standby_rst_n_i) begin
      wd_ctrl_q <= ZERO_RST;
    end else if (expire) begin
      wd_ctrl_q[WD_STAT_BIT] <= 1'b1;
    end else if (bus_i.wr && bus_i.addr == WD_CTRL_OFS) begin
      wd_ctrl_q[WD_STAT_BIT] <= bus_i.wdata[WD_STAT_BIT];
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    rdata_o = 8'h00;
    unique case (bus_i.addr)
      PIN4_CFG_OFS: rdata_o = pin_cfg_q[0];
      PIN5_CFG_OFS: rdata_o = pin_cfg_q[1];
      PIN6_CFG_OFS: rdata_o = pin_cfg_q[2];
      PIN7_CFG_OFS: rdata_o = pin_cfg_q[3];
      IRQ_TWO_OFS: rdata_o = irq_two_q;
      IRQ_ONE_OFS: rdata_o = irq_one_q;
      WD_UNITS_OFS: rdata_o = wd_units_q;
      WD_COUNT_OFS: rdata_o = wd_count_q;
      WD_CFG_OFS: rdata_o = wd_cfg_q;
      WD_CTRL_OFS: rdata_o = wd_ctrl_q;
      default: rdata_o = 8'h00;
    endcase
  end

  // pin and event synchronisers; stage one feeds stage two only
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
      ev_s1_q <= 5'h00;
      ev_s2_q <= 5'h00;
      ev_prev_q <= 5'h00;
    end else begin
      pin_s1_q <= pin_i;
      pin_s2_q <= pin_s1_q;
      ev_s1_q <= {group_one_src_i, mouse_irq_i, kbd_irq_i, game_port_access_i, ring_filter_sel_i};
      ev_s2_q <= ev_s1_q;
      ev_prev_q <= ev_s2_q;
    end
  end

  // pin 3 is index 4 of the pin vectors; it always drives the timeout status, with no gpio mode
  always_comb begin
    pin_val = 5'h00;
    pin_o = 5'h00;
    pin_oe_o = 5'h00;
    for (int i = 0; i < 4; i++) begin
      logic [7:0] c;
      logic drv;
      c = pin_cfg_q[i];
      drv = 1'b0;
      pin_val[i] = pin_s2_q[i] ^ c[PIN_POL_BIT];
      unique case (agw_fn_type'(c[PIN_FN_LO +: 2]))
        FN_ALT0: drv = parallel_data_i[i];
        FN_IRQ: drv = alt_i.irq_in[i];
        FN_GPIO: drv = c[PIN_POL_BIT]; // idle output level, no data register here
        FN_ALT3: drv = (i == 0) ? (ev_s2_q[0] ? kbc_port_bit_b_i : kbc_port_bit_a_i) : 1'b0;
      endcase
      if (!c[PIN_DIR_BIT]) begin
        if (c[PIN_OD_BIT]) begin
          pin_o[i] = 1'b0;
          pin_oe_o[i] = !drv;
        end else begin
          pin_o[i] = drv;
          pin_oe_o[i] = 1'b1;
        end
      end
    end
    pin_val[4] = pin_s2_q[4];
    // timeout indication is driven whenever the status bit is set
    pin_o[4] = wd_ctrl_q[WD_STAT_BIT];
    pin_oe_o[4] = 1'b1;
  end
  assign pin_value_o = pin_val;

  // group two collects bank-6 pins only; group one its own source
  assign grp_raw[1] = |(pin_val[3:0] & {pin_cfg_q[3][PIN_GRP_BIT], pin_cfg_q[2][PIN_GRP_BIT],
                                       pin_cfg_q[1][PIN_GRP_BIT], pin_cfg_q[0][PIN_GRP_BIT]});
  assign grp_raw[0] = ev_s2_q[4];

  // debounce: level must hold for the debounce time before it passes
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filt_q <= 2'b00;
      deb_cnt_q[0] <= 8'h00;
      deb_cnt_q[1] <= 8'h00;
    end else begin
      for (int g = 0; g < 2; g++) begin
        if (grp_raw[g] == filt_q[g]) begin
          deb_cnt_q[g] <= 8'h00;
        end else if (deb_cnt_q[g] == 8'(DEBOUNCE_CYCLES - 1)) begin
          filt_q[g] <= grp_raw[g];
          deb_cnt_q[g] <= 8'h00;
        end else begin
          deb_cnt_q[g] <= deb_cnt_q[g] + 8'h01;
        end
      end
    end
  end

  // host irq mapping; invalid and zero codes route nowhere
  always_comb begin
    logic g1, g2;
    g1 = irq_one_q[IRQ_FILT_BIT] ? filt_q[0] : grp_raw[0];
    g2 = irq_two_q[IRQ_FILT_BIT] ? filt_q[1] : grp_raw[1];
    host_irq_o = 16'h0000;
    if (irq_one_q[IRQ_MAP_LO +: 4] != IRQ_MAP_INVALID) host_irq_o[irq_one_q[IRQ_MAP_LO +: 4]] = g1;
    if (irq_two_q[IRQ_MAP_LO +: 4] != IRQ_MAP_INVALID) host_irq_o[irq_two_q[IRQ_MAP_LO +: 4]] |= g2;
    if (wd_cfg_q[WD_MAP_LO +: 4] != IRQ_MAP_INVALID) begin
      host_irq_o[wd_cfg_q[WD_MAP_LO +: 4]] |= wd_ctrl_q[WD_STAT_BIT];
    end
    host_irq_o[0] = 1'b0; // code zero disables
  end

  // reload sources are rising edges of the enabled synchronised events, plus any write to the count register
  assign reload = (wd_cfg_q[WD_GAME_BIT] && ev_s2_q[1] && !ev_prev_q[1]) ||
                  (wd_cfg_q[WD_KBD_BIT] && ev_s2_q[2] && !ev_prev_q[2]) ||
                  (wd_cfg_q[WD_MOUSE_BIT] && ev_s2_q[3] && !ev_prev_q[3]) ||
                  (bus_i.wr && bus_i.addr == WD_COUNT_OFS);

  // one second prescaler and minute prescaler; restart on reload
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sec_cnt_q <= 30'h0;
      min_cnt_q <= 6'h00;
    end else if (reload) begin
      sec_cnt_q <= 30'h0;
      min_cnt_q <= 6'h00;
    end else if (tick_sec) begin
      sec_cnt_q <= 30'h0;
      min_cnt_q <= (min_cnt_q == 6'(SECS_PER_MIN - 1)) ? 6'h00 : min_cnt_q + 6'h01;
    end else begin
      sec_cnt_q <= sec_cnt_q + 30'h1;
    end
  end
  assign tick_sec = sec_cnt_q == 30'(SEC_CYCLES - 1);
  assign unit_tick = tick_sec && (wd_units_q[WD_SEC_BIT] || min_cnt_q == 6'(SECS_PER_MIN - 1));

  // unit countdown; zero count holds the watchdog off
  assign expire = wd_count_q != 8'h00 && !reload && unit_tick && wd_left_q == 8'h01;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_left_q <= 8'h00;
    end else if (reload) begin
      // reload first so a count written while the register is still zero loads at once
      wd_left_q <= (bus_i.wr && bus_i.addr == WD_COUNT_OFS) ? bus_i.wdata : wd_count_q;
    end else if (wd_count_q == 8'h00) begin
      wd_left_q <= 8'h00;
    end else if (unit_tick && wd_left_q != 8'h00) begin
      wd_left_q <= wd_left_q - 8'h01;
    end
  end

  // led toggles each half second while status set and blink enabled
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_q <= 1'b0;
    end else if (!(wd_cfg_q[WD_LED_BIT] && wd_ctrl_q[WD_STAT_BIT])) begin
      led_q <= 1'b0;
    end else if (sec_cnt_q == 30'(SEC_CYCLES / 2 - 1) || tick_sec) begin
      led_q <= !led_q;
    end
  end
  assign power_led_output_o = led_q;
  assign watchdog_timeout_output_o = wd_ctrl_q[WD_STAT_BIT];

  a_pin_reset_value: assert property (@(posedge ref_clk_i) $rose(rst_n_i) |-> pin_cfg_q[0] == 8'h01)
    else $error("pin cfg not 0x01 after reset");
  a_stat_on_expire: assert property (@(posedge ref_clk_i) disable iff (!standby_rst_n_i)
    expire |=> wd_ctrl_q[WD_STAT_BIT] && watchdog_timeout_output_o)
    else $error("status not set after expiry");
  a_count_zero_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wd_count_q == 8'h00 |-> !expire)
    else $error("expiry while watchdog disabled");
  a_soft_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i || !standby_rst_n_i)
    soft_rst |=> wd_units_q == 8'h00 && wd_count_q == 8'h00 && (wd_cfg_q & 8'hfd) == 8'h00)
    else $error("soft reset did not clear watchdog");
  a_irq_low_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    irq_one_q[2:0] == 3'b000 && irq_two_q[2:0] == 3'b000)
    else $error("reserved irq bits nonzero");
  a_led_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !wd_cfg_q[WD_LED_BIT] |=> !power_led_output_o)
    else $error("led blinks while disabled");
  a_input_no_drive: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    pin_cfg_q[1][0] |-> !pin_oe_o[1])
    else $error("input pin driven");
  a_polarity: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    pin_value_o[2] == (pin_s2_q[2] ^ pin_cfg_q[2][1]))
    else $error("polarity wrong");
  a_reload_restart: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    reload && wd_count_q != 8'h00 && !(bus_i.wr && bus_i.addr == WD_COUNT_OFS) |=> wd_left_q == $past(wd_count_q))
    else $error("reload did not restart count");
endmodule : agw_aux_gpio
`default_nettype wire

// ==== agw_aux_gpio_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module agw_aux_gpio_tb_top;
  import agw_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} agw_row_type;
  // address, written value, value read back after the write
  localparam agw_row_type ROWS [0:11] = '{'{8'hd4, 8'hff, 8'hbb}, '{8'hd5, 8'h5a, 8'h1a}, '{8'hd6, 8'h44, 8'h00},
    '{8'hd7, 8'h80, 8'h80}, '{8'hef, 8'hff, 8'hf8}, '{8'hf0, 8'h27, 8'h20}, '{8'hf1, 8'hff, 8'h80},
    '{8'hf2, 8'hff, 8'hff}, '{8'hf3, 8'hff, 8'hff}, '{8'h10, 8'hff, 8'h00}, '{8'hf2, 8'h00, 8'h00},
    '{8'hf3, 8'h00, 8'h00}};
  localparam logic [7:0] REGS [0:9] = '{8'hd4, 8'hd5, 8'hd6, 8'hd7, 8'hef, 8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf4};
  logic ref_clk, rst_n, main_rst_n, bus_rst, standby_rst_n;
  logic ring_sel, game_acc, kbd_irq, mouse_irq, grp_one, kbc_a, kbc_b;
  logic [4:0] pin_in, pin_out, pin_oe, pin_val;
  logic [3:0] par_data;
  logic [15:0] host_irq;
  logic [7:0] rdata;
  logic led, wd_out;
  agw_bus_type bus;
  agw_alt_type alt;
  int n_fail = 0;
  int num_checks = 0;
  agw_aux_gpio u_agw_aux_gpio (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .main_rst_n_i(main_rst_n), .bus_rst_i(bus_rst),
    .standby_rst_n_i(standby_rst_n), .bus_i(bus), .rdata_o(rdata), .pin_i(pin_in), .pin_o(pin_out),
    .pin_oe_o(pin_oe), .alt_i(alt), .parallel_data_i(par_data), .kbc_port_bit_a_i(kbc_a), .kbc_port_bit_b_i(kbc_b),
    .ring_filter_sel_i(ring_sel), .game_port_access_i(game_acc), .kbd_irq_i(kbd_irq), .mouse_irq_i(mouse_irq),
    .group_one_src_i(grp_one), .host_irq_o(host_irq), .pin_value_o(pin_val), .power_led_output_o(led),
    .watchdog_timeout_output_o(wd_out));
  agw_host_model u_agw_host_model (.ref_clk_i(ref_clk), .rdata_i(rdata), .bus_o(bus));
  // free-running 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_agw_host_model.rd(a, d);
    chk(16'(d), 16'(e));
  endtask : rchk
  // sample one time unit past the edge so that edge's updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_agw_host_model.wr(a, d);
  endtask : wr
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  // hang guard, well past the fewer than a thousand cycles the sequence needs
  initial begin
    #80000;
    n_fail++;
    results();
  end
  initial begin
    {rst_n, main_rst_n, standby_rst_n, bus_rst} = 4'h0;
    {ring_sel, game_acc, kbd_irq, mouse_irq, grp_one, kbc_a, kbc_b} = 7'h00;
    pin_in = 5'h00;
    par_data = 4'h0;
    alt = '0;
    repeat (4) @(posedge ref_clk);
    {rst_n, main_rst_n, standby_rst_n} <= 3'h7;
    cyc(1);
    chk(16'({pin_oe, pin_out[4]}), 16'h20);
    for (int i = 0; i < 10; i++) rchk(REGS[i], (i < 4) ? 8'h01 : 8'h00);
    // ordinary register writes with read-back, reserved bits and an unmapped index
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      rchk(ROWS[i].a, ROWS[i].e);
    end
    // output drive: push-pull high, open-drain releases a high, open-drain pulls low
    wr(8'hd4, 8'h12);
    cyc(1);
    chk(16'({pin_oe[0], pin_out[0]}), 16'h3);
    wr(8'hd4, 8'h92);
    cyc(1);
    chk(16'(pin_oe[0]), 16'h0);
    wr(8'hd4, 8'h90);
    cyc(1);
    chk(16'({pin_oe[0], pin_out[0]}), 16'h2);
    // alternate functions: parallel data, then keyboard-controller bit picked by ring select
    par_data <= 4'h1;
    wr(8'hd4, 8'h00);
    wr(8'hd5, 8'h00);
    cyc(1);
    chk(16'({pin_oe[1:0], pin_out[1:0]}), 16'hd);
    kbc_a <= 1'b1;
    wr(8'hd4, 8'h18);
    cyc(4);
    chk(16'(pin_out[0]), 16'h1);
    ring_sel <= 1'b1;
    cyc(4);
    chk(16'(pin_out[0]), 16'h0);
    // input polarity on the synchronised value
    pin_in <= 5'h01;
    wr(8'hd4, 8'h01);
    cyc(4);
    chk(16'(pin_val[0]), 16'h1);
    wr(8'hd4, 8'h03);
    cyc(4);
    chk(16'(pin_val[0]), 16'h0);
    // combined interrupt two from pin 5, interrupt one from its own source only
    pin_in <= 5'h03;
    wr(8'hd5, 8'h21);
    wr(8'hef, 8'h30);
    wr(8'hf0, 8'hf0);
    cyc(6);
    chk(host_irq, 16'h0008);
    grp_one <= 1'b1;
    cyc(6);
    chk(host_irq, 16'h8008);
    wr(8'hd5, 8'h01);
    cyc(6);
    chk(host_irq, 16'h8000);
    wr(8'hd5, 8'h21);
    wr(8'hef, 8'h20);
    cyc(6);
    chk(host_irq, 16'h8000);
    // debounce: a rise must not pass at once, but must pass after the filter time
    pin_in <= 5'h01;
    wr(8'hef, 8'h38);
    cyc(300);
    pin_in <= 5'h03;
    cyc(20);
    chk(16'(host_irq[3]), 16'h0);
    cyc(300);
    chk(16'(host_irq[3]), 16'h1);
    // software status flag drives the timeout pin; reload events alone never raise it
    wr(8'hf4, 8'h01);
    cyc(1);
    chk(16'({wd_out, pin_oe[4], pin_out[4]}), 16'h7);
    chk(16'(led), 16'h0);
    wr(8'hf4, 8'h00);
    wr(8'hf2, 8'h05);
    wr(8'hf3, 8'h07);
    {game_acc, kbd_irq, mouse_irq} <= 3'h7;
    cyc(6);
    chk(16'({wd_out, pin_out[4]}), 16'h0);
    // main-supply and bus resets clear units and count, keep config bit 1 and status
    for (int k = 0; k < 2; k++) begin
      wr(8'hf1, 8'h80);
      wr(8'hf2, 8'h33);
      wr(8'hf3, 8'hff);
      wr(8'hf4, 8'h01);
      if (k == 0) bus_rst <= 1'b1;
      else main_rst_n <= 1'b0;
      cyc(1);
      {bus_rst, main_rst_n} <= 2'h1;
      for (int i = 6; i < 10; i++) rchk(REGS[i], (i == 8) ? 8'h02 : ((i == 9) ? 8'h01 : 8'h00));
    end
    // standby reset clears watchdog config and status, battery reset restores pin config
    standby_rst_n <= 1'b0;
    cyc(1);
    standby_rst_n <= 1'b1;
    rchk(8'hf3, 8'h00);
    rchk(8'hf4, 8'h00);
    rchk(8'hd5, 8'h21);
    rst_n <= 1'b0;
    cyc(1);
    rst_n <= 1'b1;
    rchk(8'hd5, 8'h01);
    results();
  end
endmodule : agw_aux_gpio_tb_top
`default_nettype wire

// ==== agw_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// host side of the configuration port: one access at a time, launched just after a clock edge
module agw_host_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] rdata_i,
  output var agw_pkg::agw_bus_type bus_o
);
  import agw_pkg::*;
  // idle bus at time zero
  initial begin
    bus_o = '0;
  end
  // one-cycle write strobe; address and data are scrambled after release so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    bus_o.addr <= a;
    bus_o.wdata <= d;
    bus_o.wr <= 1'b1;
    @(posedge ref_clk_i);
    bus_o.wr <= 1'b0;
    bus_o.addr <= ~a;
    bus_o.wdata <= ~d;
  endtask : wr
  // reads are combinational, so data is taken at the edge after the index settles
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    bus_o.addr <= a;
    bus_o.rd <= 1'b1;
    @(posedge ref_clk_i);
    d = rdata_i;
    bus_o.rd <= 1'b0;
    bus_o.addr <= ~a;
  endtask : rd
endmodule : agw_host_model
`default_nettype wire

// ==== agw_pkg.sv ====
package agw_pkg;
  // register indices on the configuration port
  localparam logic [7:0] PIN4_CFG_OFS = 8'hd4;
  localparam logic [7:0] PIN5_CFG_OFS = 8'hd5;
  localparam logic [7:0] PIN6_CFG_OFS = 8'hd6;
  localparam logic [7:0] PIN7_CFG_OFS = 8'hd7;
  localparam logic [7:0] IRQ_TWO_OFS = 8'hef;
  localparam logic [7:0] IRQ_ONE_OFS = 8'hf0;
  localparam logic [7:0] WD_UNITS_OFS = 8'hf1;
  localparam logic [7:0] WD_COUNT_OFS = 8'hf2;
  localparam logic [7:0] WD_CFG_OFS = 8'hf3;
  localparam logic [7:0] WD_CTRL_OFS = 8'hf4;
  // reset values
  localparam logic [7:0] PIN_CFG_RST = 8'h01;
  localparam logic [7:0] ZERO_RST = 8'h00;
  // pin configuration fields
  localparam int PIN_DIR_BIT = 0;
  localparam int PIN_POL_BIT = 1;
  localparam int PIN_FN_LO = 3;
  localparam int PIN_GRP_BIT = 5;
  localparam int PIN_OD_BIT = 7;
  localparam logic [7:0] PIN_CFG_WMASK = 8'hbb;
  // combined interrupt fields
  localparam int IRQ_FILT_BIT = 3;
  localparam int IRQ_MAP_LO = 4;
  localparam logic [7:0] IRQ_CFG_WMASK = 8'hf8;
  localparam logic [3:0] IRQ_MAP_INVALID = 4'h2;
  // watchdog fields
  localparam int WD_SEC_BIT = 7;
  localparam logic [7:0] WD_UNITS_WMASK = 8'h80;
  localparam int WD_GAME_BIT = 0;
  localparam int WD_KBD_BIT = 1;
  localparam int WD_MOUSE_BIT = 2;
  localparam int WD_LED_BIT = 3;
  localparam int WD_MAP_LO = 4;
  localparam logic [7:0] WD_CFG_HOSTCLR = 8'h02;
  localparam int WD_STAT_BIT = 0;
  // timing
  localparam longint CLK_HZ = 250000000;
  localparam longint SEC_NS = 1000000000;
  localparam longint CLK_NS = 4;
  localparam longint SEC_CYCLES = SEC_NS / CLK_NS;
  localparam int SECS_PER_MIN = 60;
  localparam int DEBOUNCE_NS = 1000;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + 3) / 4;
  // function codes
  typedef enum logic [1:0] {FN_ALT0, FN_IRQ, FN_GPIO, FN_ALT3} agw_fn_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } agw_bus_type;
  typedef struct packed {
    logic [3:0] alt_in;
    logic [3:0] irq_in;
  } agw_alt_type;
endpackage : agw_pkg
